// File: design/spd_ctrl.sv
// Speed profile controller with four data sets and APB registers
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module spd_ctrl
  import spd_pkg::*;
#(
  parameter int TICK_CYC = spd_pkg::TICK_DIV
)(
  input  wire logic                    mclk,
  input  wire logic                    reset,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  input  wire logic                    data_select_bit0,
  input  wire logic                    data_select_bit1,
  input  wire logic                    dial_we,
  input  wire spd_pkg::spd_item_t      dial_item,
  input  wire logic [12:0]             dial_val,
  input  wire logic [7:0]              pot_acc,
  input  wire logic [7:0]              pot_dec,
  input  wire logic                    ext_stop,
  input  wire logic                    alarm_in,
  input  wire logic                    alarm_latch,
  input  wire logic [7:0]              alarm_code_in,
  input  wire logic                    warn_in,
  input  wire logic signed [7:0]       shaft_dev,
  output logic [12:0]                  speed_cmd,
  output logic                         drive_en,
  output logic                         brake,
  output logic signed [7:0]            hold_torque,
  output logic [7:0]                   alarm_code,
  output logic                         warning,
  output logic                         lock_notice_display,
  output logic                         irq
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // The tick needs at least two cycles so the divider can wrap
  if (TICK_CYC < 2)
  begin : g_bad_tick
    $error("TICK_CYC too small");
  end
  // The notice counter is 11 bits wide
  if (LOCK_TICKS > 2047)
  begin : g_bad_note
    $error("LOCK_TICKS does not fit the notice counter");
  end
  // The fixed-point command must hold the top speed
  if ((SPD_MAX << FRAC) > 24'h7FFFFF)
  begin : g_bad_frac
    $error("FRAC too large for the command register");
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  spd_set_t        set_r [NSETS];
  logic [3:0]      ctrl_r;
  logic [12:0]     lo_r;
  logic [12:0]     hi_r;
  logic [NIRQ-1:0] ist_r;
  logic [NIRQ-1:0] ien_r;
  logic [22:0]     cmd_r;
  logic [31:0]     div_r;
  logic [10:0]     note_r;
  logic [7:0]      acode_r;
  logic            alarm_r;
  logic            sticky_r;
  logic            ext_r;
  logic            warn_r;
  spd_state_t      st_r;
  spd_state_t      st_nxt;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire         acc_p = psel & penable;
  wire         wr_p  = acc_p & pwrite;
  wire [1:0]   a_set = paddr[3:2];
  wire         in_sp = paddr[7:4] == A_SETSP[7:4];
  wire         in_ac = paddr[7:4] == A_SETAC[7:4];
  wire         in_dc = paddr[7:4] == A_SETDC[7:4];
  wire         in_gp = paddr[7:5] == 3'h0;
  wire         mapped = (in_sp | in_ac | in_dc | in_gp) & (paddr[1:0] == 2'h0);
  wire         w_ctrl = wr_p & (paddr == A_CTRL);
  wire         w_lim  = wr_p & (paddr == A_LIMIT);
  wire         w_cmd  = wr_p & (paddr == A_CMD);
  wire         w_ien  = wr_p & (paddr == A_IEN);
  wire         w_iclr = wr_p & (paddr == A_ICLR);
  wire         w_set  = wr_p & mapped & (in_sp | in_ac | in_dc);

  assign pready  = acc_p;
  assign pslverr = acc_p & ~mapped;

  // ----------------------------------------
  // Shared edit path: software first, dial when unlocked
  // ----------------------------------------
  wire [1:0]  act    = {data_select_bit1, data_select_bit0};
  wire        locked = ctrl_r[C_LOCK];
  wire        dial_ok = dial_we & ~locked & ~w_set;
  wire        dial_lk = dial_we & locked;
  wire        e_we   = w_set | dial_ok;
  wire [1:0]  e_set  = w_set ? a_set : act;
  wire [1:0]  e_item = w_set ? (in_sp ? IT_SPEED : in_ac ? IT_ACC : IT_DEC) : dial_item;
  wire [12:0] e_val  = w_set ? pwdata[12:0] : dial_val;
  wire        e_hi   = |e_val[12:8];
  wire [7:0]  e_t    = e_val[7:0];
  wire        sp_ok  = (e_val == 13'h0000) | ((e_val >= lo_r) & (e_val <= hi_r));
  wire        t_ok   = ~e_hi & (e_t >= T_MIN) & (e_t <= T_MAX);
  wire        e_init = e_we & (e_item == IT_INIT);
  wire        k_init = w_cmd & pwdata[K_INIT];
  wire        ok     = (e_item == IT_SPEED) ? sp_ok : (e_item == IT_INIT) | t_ok;
  wire        rej    = e_we & ~ok;
  wire        lim_ok = (pwdata[12:0] >= SPD_MIN) & (pwdata[LIM_UP+12:LIM_UP] <= SPD_MAX)
                     & (pwdata[12:0] <= pwdata[LIM_UP+12:LIM_UP]);

  // ----------------------------------------
  // Data sets
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < NSETS; i++)
    begin
      if (reset)
      begin
        set_r[i] <= '{SPD_DEF, T_DIG_DEF, T_DIG_DEF};
      end
      else if ((k_init && pwdata[1:0] == i[1:0]) || (e_init && e_set == i[1:0]))
      begin
        set_r[i] <= '{SPD_DEF, T_DIG_DEF, T_DIG_DEF};
      end
      else if (e_we && ok && e_set == i[1:0])
      begin
        if (e_item == IT_SPEED) set_r[i].speed <= e_val;
        if (e_item == IT_ACC) set_r[i].acc <= e_t;
        if (e_item == IT_DEC) set_r[i].dec <= e_t;
      end
      else if (set_r[i].speed != 13'h0000 && set_r[i].speed > hi_r)
      begin
        set_r[i].speed <= hi_r;
      end
      else if (set_r[i].speed != 13'h0000 && set_r[i].speed < lo_r)
      begin
        set_r[i].speed <= lo_r;
      end
    end
  end

  // ----------------------------------------
  // Control and limits
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl_r <= 4'h0;
      lo_r   <= SPD_MIN;
      hi_r   <= SPD_MAX;
      ien_r  <= '0;
    end
    else
    begin
      if (w_ctrl) ctrl_r <= pwdata[3:0];
      if (w_lim && lim_ok) lo_r <= pwdata[12:0];
      if (w_lim && lim_ok) hi_r <= pwdata[LIM_UP+12:LIM_UP];
      if (w_ien) ien_r <= pwdata[NIRQ-1:0];
    end
  end

  // ----------------------------------------
  // Millisecond tick and lock notice
  // ----------------------------------------
  wire tick = div_r == TICK_CYC - 1;

  always_ff @(posedge mclk)
  begin
    if (reset || tick) div_r <= '0;
    else div_r <= div_r + 32'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (reset) note_r <= '0;
    else if (dial_lk) note_r <= 11'(LOCK_TICKS);
    else if (tick && note_r != 11'h000) note_r <= note_r - 11'h001;
  end

  assign lock_notice_display = note_r != 11'h000;

  // ----------------------------------------
  // Alarms, warnings and external stop code
  // ----------------------------------------
  wire a_clr = w_cmd & pwdata[K_ACLR] & ~sticky_r & ~alarm_in;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      alarm_r  <= 1'b0;
      sticky_r <= 1'b0;
      acode_r  <= 8'h00;
      ext_r    <= 1'b0;
      warn_r   <= 1'b0;
    end
    else
    begin
      warn_r <= warn_in;
      if (alarm_in && !alarm_r)
      begin
        alarm_r  <= 1'b1;
        sticky_r <= alarm_latch;
        acode_r  <= alarm_code_in;
      end
      else if (a_clr)
      begin
        alarm_r <= 1'b0;
        acode_r <= 8'h00;
      end
      else if (ext_stop && !alarm_r)
      begin
        acode_r <= EXT_STOP_CD;
      end
      else if (!ext_stop && ext_r && !alarm_r)
      begin
        acode_r <= 8'h00;
      end
      ext_r <= ext_stop;
    end
  end

  // ----------------------------------------
  // Stop state
  // ----------------------------------------
  // Latching alarms keep the drive off until reset, which stands for the power cycle
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_RUN:
      begin
        if (alarm_in || alarm_r) st_nxt = ST_COAST;
        else if (ext_stop) st_nxt = ST_BRAKE;
      end
      ST_COAST:
      begin
        if (!alarm_r && !alarm_in) st_nxt = ST_RUN;
      end
      ST_BRAKE:
      begin
        if (alarm_in) st_nxt = ST_COAST;
        else if (!ext_stop && !ctrl_r[C_RUN]) st_nxt = ST_RUN;
      end
      default: st_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset) st_r <= ST_RUN;
    else st_r <= st_nxt;
  end

  assign alarm_code = acode_r;
  assign warning    = warn_r;

  // ----------------------------------------
  // Ramp generator
  // ----------------------------------------
  spd_set_t    cur;
  assign cur = set_r[act];
  wire         digital = ctrl_r[C_DIGITAL];
  wire         running = (st_r == ST_RUN) & ctrl_r[C_RUN];
  wire [12:0]  tgt     = running ? cur.speed : 13'h0000;
  wire [7:0]   pa      = (pot_acc < T_MIN) ? T_MIN : (pot_acc > T_MAX) ? T_MAX : pot_acc;
  wire [7:0]   pd      = (pot_dec < T_MIN) ? T_MIN : (pot_dec > T_MAX) ? T_MAX : pot_dec;
  wire [7:0]   ta      = digital ? cur.acc : pa;
  wire [7:0]   td      = digital ? cur.dec : pd;
  wire [12:0]  span    = digital ? cur.speed : SPD_RATED;
  wire [23:0]  span_f  = {11'h000, span} << FRAC;
  wire [23:0]  st_a    = span_f / (24'(ta) * 24'(TICKS_PER_T));
  wire [23:0]  st_d    = span_f / (24'(td) * 24'(TICKS_PER_T));
  wire [23:0]  stp_a   = (st_a == 24'h0) ? 24'h1 : st_a;
  wire [23:0]  stp_d   = (st_d == 24'h0) ? 24'h1 : st_d;
  wire [23:0]  cmd_w   = {1'b0, cmd_r};
  wire [23:0]  tgt_f   = {11'h000, tgt} << FRAC;
  wire [23:0]  up      = cmd_w + stp_a;
  wire [23:0]  dn      = (cmd_w > stp_d) ? cmd_w - stp_d : 24'h0;
  // Cleared on the edge that takes the stop, so a stopped drive never shows a stale command
  wire         stop_now = (st_r != ST_RUN) | (st_nxt != ST_RUN);

  always_ff @(posedge mclk)
  begin
    if (reset || stop_now) cmd_r <= '0;
    else if (tick && cmd_w < tgt_f) cmd_r <= (up > tgt_f) ? tgt_f[22:0] : up[22:0];
    else if (tick && cmd_w > tgt_f) cmd_r <= (dn < tgt_f) ? tgt_f[22:0] : dn[22:0];
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign speed_cmd = cmd_r[22:FRAC];
  assign drive_en  = st_r == ST_RUN;
  assign brake     = st_r == ST_BRAKE;

  // ----------------------------------------
  // Holding torque
  // ----------------------------------------
  // Proportional to deviation, saturated at half rated so a held load cannot overdrive
  wire standstill = (cmd_r == 23'h0) & (st_r == ST_RUN);
  wire hold_on    = ctrl_r[C_HOLD] & standstill;
  wire signed [7:0] hmax = HOLD_PCT;
  wire signed [7:0] sat  = (shaft_dev > hmax) ? hmax : (shaft_dev < -hmax) ? -hmax : shaft_dev;
  assign hold_torque = hold_on ? sat : 8'sh00;

  // ----------------------------------------
  // Interrupts: set beats clear
  // ----------------------------------------
  wire [NIRQ-1:0] ev;
  assign ev[I_ALARM] = alarm_in & ~alarm_r;
  assign ev[I_WARN]  = warn_in & ~warn_r;
  assign ev[I_EXT]   = ext_stop & ~ext_r;
  assign ev[I_LOCK]  = dial_lk;
  assign ev[I_REJ]   = rej;

  always_ff @(posedge mclk)
  begin
    if (reset) ist_r <= '0;
    else ist_r <= ev | (ist_r & ~(w_iclr ? pwdata[NIRQ-1:0] : '0));
  end

  assign irq = |(ist_r & ien_r);

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [31:0] stat_w = {8'h00, acode_r, 8'h00, 1'b0, sticky_r, alarm_r, warn_r,
                        lock_notice_display, brake, act};
  always_comb
  begin
    prdata = 32'h0;
    if (in_sp) prdata = {19'h0, set_r[a_set].speed};
    else if (in_ac) prdata = {24'h0, set_r[a_set].acc};
    else if (in_dc) prdata = {24'h0, set_r[a_set].dec};
    else if (paddr == A_CTRL) prdata = {28'h0, ctrl_r};
    else if (paddr == A_LIMIT) prdata = {3'h0, hi_r, 3'h0, lo_r};
    else if (paddr == A_STAT) prdata = stat_w;
    else if (paddr == A_SPEED) prdata = {19'h0, speed_cmd};
    else if (paddr == A_ISTAT) prdata = {27'h0, ist_r};
    else if (paddr == A_IEN) prdata = {27'h0, ien_r};
  end

endmodule // spd_ctrl

// File: design/spd_pkg.sv
// Shared constants and types of the speed profile controller
package spd_pkg;
  localparam int          CLK_HZ       = 50000000;
  localparam int          TICK_US      = 1000;
  localparam int          TICK_DIV     = CLK_HZ / 1000000 * TICK_US;
  localparam int          LOCK_NOTE_MS = 1000;
  localparam int          LOCK_TICKS   = LOCK_NOTE_MS * 1000 / TICK_US;
  localparam int          PWR_OFF_S    = 60;
  localparam int          NSETS        = 4;
  localparam logic [12:0] SPD_MIN      = 13'h0032;
  localparam logic [12:0] SPD_MAX      = 13'h0FA0;
  localparam logic [12:0] SPD_RATED    = 13'h0BB8;
  localparam logic [12:0] SPD_DEF      = 13'h0032;
  localparam logic [7:0]  T_MIN        = 8'h01;
  localparam logic [7:0]  T_MAX        = 8'h96;
  localparam logic [7:0]  T_DIG_DEF    = 8'h05;
  localparam logic [7:0]  T_POT_DEF    = 8'h01;
  localparam logic [7:0]  HOLD_PCT     = 8'h32;
  localparam logic [7:0]  EXT_STOP_CD  = 8'h68;
  localparam int          FRAC         = 10;
  localparam int          TICKS_PER_T  = 100;
  // Register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_LIMIT = 8'h04;
  localparam logic [7:0] A_CMD   = 8'h08;
  localparam logic [7:0] A_STAT  = 8'h0C;
  localparam logic [7:0] A_SPEED = 8'h10;
  localparam logic [7:0] A_ISTAT = 8'h14;
  localparam logic [7:0] A_IEN   = 8'h18;
  localparam logic [7:0] A_ICLR  = 8'h1C;
  localparam logic [7:0] A_SETSP = 8'h20;
  localparam logic [7:0] A_SETAC = 8'h30;
  localparam logic [7:0] A_SETDC = 8'h40;
  // Control bits, command bits and the upper limit field offset
  localparam int C_DIGITAL = 0;
  localparam int C_HOLD    = 1;
  localparam int C_LOCK    = 2;
  localparam int C_RUN     = 3;
  localparam int K_INIT    = 8;
  localparam int K_ACLR    = 9;
  localparam int LIM_UP    = 16;
  // Interrupt bits
  localparam int I_ALARM = 0;
  localparam int I_WARN  = 1;
  localparam int I_EXT   = 2;
  localparam int I_LOCK  = 3;
  localparam int I_REJ   = 4;
  localparam int NIRQ    = 5;
  typedef struct packed {
    logic [12:0] speed;
    logic [7:0]  acc;
    logic [7:0]  dec;
  } spd_set_t;
  typedef enum logic [1:0] {IT_SPEED, IT_ACC, IT_DEC, IT_INIT} spd_item_t;
  typedef enum {ST_RUN, ST_COAST, ST_BRAKE} spd_state_t;
endpackage

// File: verification/spd_ctl_model.sv
// Stand-in for the external controller and the motor shaft
`timescale 1ns/1ps
module spd_ctl_model
(
  input  wire logic              mclk,
  input  wire logic [1:0]        set_no,
  input  wire logic signed [7:0] drift,
  input  wire logic [12:0]       speed_cmd,
  output logic                   data_select_bit0,
  output logic                   data_select_bit1,
  output logic signed [7:0]      shaft_dev
);
  // ----------------------------------------
  // Select lines and shaft deflection
  // ----------------------------------------
  // Bench changes set_no just after an edge, so the selects never move on one
  assign data_select_bit0 = set_no[0];
  assign data_select_bit1 = set_no[1];
  // Load only deflects the shaft while the command is at standstill
  assign shaft_dev = (speed_cmd == 13'h0000) ? drift : 8'sh00;
endmodule // spd_ctl_model

// File: verification/spd_ctrl_chk.sv
// Concurrent checks on the speed profile controller ports
`timescale 1ns/1ps
module spd_ctrl_chk
  import spd_pkg::*;
#(
  parameter int TICK_CYC = TICK_DIV
)(
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic              alarm_in,
  input wire logic              ext_stop,
  input wire logic              warn_in,
  input wire logic [12:0]       speed_cmd,
  input wire logic              drive_en,
  input wire logic              brake,
  input wire logic signed [7:0] hold_torque,
  input wire logic              warning,
  input wire logic              lock_notice_display
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_speed_max: assert property (speed_cmd <= SPD_MAX)
    else $error("speed command above top speed");
  a_hold_sat: assert property (hold_torque <= 8'sd50 && hold_torque >= -8'sd50)
    else $error("holding torque beyond half rating");
  a_hold_run: assert property (speed_cmd != 13'h0000 |-> hold_torque == 8'sh00)
    else $error("holding torque while turning");
  a_alarm_coast: assert property ($rose(alarm_in) |=> !drive_en && speed_cmd == 13'h0000)
    else $error("alarm did not coast the motor");
  a_coast_nohold: assert property (!drive_en |-> hold_torque == 8'sh00 && speed_cmd == 13'h0000)
    else $error("coasting with torque or speed");
  a_ext_brake: assert property ($rose(ext_stop) && drive_en && !alarm_in |=> brake)
    else $error("external stop did not brake");
  a_brake_out: assert property (brake |-> speed_cmd == 13'h0000 && hold_torque == 8'sh00)
    else $error("braking with speed or torque");
  a_warn_follow: assert property ($rose(warn_in) |=> warning)
    else $error("warning not raised");
  a_notice_min: assert property ($rose(lock_notice_display) |-> lock_notice_display[*8])
    else $error("lock notice too short");
  // Speed may only step once per tick, never on consecutive cycles
  a_ramp_step: assert property (($changed(speed_cmd) && drive_en && !brake && !alarm_in)
    |=> ($stable(speed_cmd) || !drive_en || brake))
    else $error("speed stepped twice in a row");
  c_alarm: cover property ($fell(drive_en));
  c_brake: cover property ($rose(brake));
  c_notice: cover property ($rose(lock_notice_display));
endmodule // spd_ctrl_chk

bind spd_ctrl spd_ctrl_chk #(.TICK_CYC(TICK_CYC)) spd_ctrl_chk_i (.mclk(mclk), .reset(reset),
  .alarm_in(alarm_in), .ext_stop(ext_stop), .warn_in(warn_in), .speed_cmd(speed_cmd), .drive_en(drive_en),
  .brake(brake), .hold_torque(hold_torque), .warning(warning), .lock_notice_display(lock_notice_display));

// File: verification/test_spd_ctrl.sv
// Self-checking bench for the speed profile controller
`timescale 1ns/1ps
module test_spd_ctrl;
  import spd_pkg::*;
  // ----------------------------------------
  // Signals, design and partner
  // ----------------------------------------
  logic              mclk, reset, psel, penable, pwrite, pready, pslverr, dial_we, ext_stop, alarm_in;
  logic              alarm_latch, warn_in, sel0, sel1, drive_en, brake, warning, lock_notice_display, irq, er;
  logic [7:0]        paddr, pot_acc, pot_dec, alarm_code_in, alarm_code;
  logic [31:0]       pwdata, prdata, rd;
  logic [12:0]       dial_val, speed_cmd;
  logic [1:0]        set_no;
  logic signed [7:0] drift, shaft_dev, hold_torque;
  spd_item_t         dial_item;
  int                n_errors = 0;
  int                checks_done = 0;
  int                c;
  spd_ctrl #(.TICK_CYC(50)) spd_ctrl_i (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .data_select_bit0(sel0), .data_select_bit1(sel1), .dial_we(dial_we), .dial_item(dial_item),
    .dial_val(dial_val), .pot_acc(pot_acc), .pot_dec(pot_dec), .ext_stop(ext_stop), .alarm_in(alarm_in),
    .alarm_latch(alarm_latch), .alarm_code_in(alarm_code_in), .warn_in(warn_in), .shaft_dev(shaft_dev),
    .speed_cmd(speed_cmd), .drive_en(drive_en), .brake(brake), .hold_torque(hold_torque),
    .alarm_code(alarm_code), .warning(warning), .lock_notice_display(lock_notice_display), .irq(irq));
  spd_ctl_model spd_ctl_model_i (.mclk(mclk), .set_no(set_no), .drift(drift), .speed_cmd(speed_cmd),
    .data_select_bit0(sel0), .data_select_bit1(sel1), .shaft_dev(shaft_dev));
  always #10 mclk = ~mclk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    end_of_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  // Holds the request until pready is seen high at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
    begin
      if (++n > 16) hang();
      @(posedge mclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  function automatic logic [7:0] at(input logic [7:0] b, input int i);
    return 8'(b + 4 * i);
  endfunction
  task automatic dl(input spd_item_t it, input logic [12:0] v);
    dial_item <= it;
    dial_val <= v;
    dial_we <= 1'b1;
    @(posedge mclk);
    dial_we <= 1'b0;
    @(posedge mclk);
  endtask
  // Tolerance covers the unknown phase of the 50-cycle tick
  task automatic ramp(input logic [12:0] tgt, input int t);
    int k;
    k = 0;
    while (speed_cmd !== tgt)
    begin
      @(posedge mclk);
      if (++k > 20000) hang();
    end
    chk(k > t * 50 - 60 && k < t * 50 + 60, 1);
  endtask
  task automatic pass2();
    repeat (2) @(posedge mclk);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {mclk, psel, penable, pwrite, dial_we, ext_stop, alarm_in, alarm_latch, warn_in} = '0;
    reset = 1'b1;
    {paddr, pwdata, dial_val, set_no, drift, alarm_code_in} = '0;
    dial_item = IT_SPEED;
    pot_acc = 8'h01;
    pot_dec = 8'h02;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 4; i++)
    begin
      rc(at(A_SETSP, i), 32'h32);
      rc(at(A_SETAC, i), 32'h5);
      rc(at(A_SETDC, i), 32'h5);
    end
    rc(A_CTRL, 32'h0);
    rc(A_LIMIT, 32'h0FA00032);
    bus(1'b0, 8'hFC, 32'h0);
    chk(er, 1);
    $display("test reset done");
    wr(at(A_SETSP, 1), 32'hFA0);
    rc(at(A_SETSP, 1), 32'hFA0);
    wr(at(A_SETSP, 1), 32'hFA1);
    rc(at(A_SETSP, 1), 32'hFA0);
    wr(at(A_SETSP, 2), 32'h0);
    rc(at(A_SETSP, 2), 32'h0);
    wr(at(A_SETSP, 3), 32'h31);
    rc(at(A_SETSP, 3), 32'h32);
    rc(A_ISTAT, 32'h10);
    wr(at(A_SETAC, 0), 32'h97);
    rc(at(A_SETAC, 0), 32'h5);
    wr(at(A_SETAC, 0), 32'h96);
    rc(at(A_SETAC, 0), 32'h96);
    wr(at(A_SETDC, 0), 32'h0);
    rc(at(A_SETDC, 0), 32'h5);
    for (int i = 0; i < 4; i++)
    begin
      set_no <= 2'(i);
      pass2();
      dl(IT_SPEED, 13'(100 + i));
    end
    for (int i = 0; i < 4; i++)
      rc(at(A_SETSP, i), 32'(100 + i));
    wr(A_CMD, 32'h102);
    rc(at(A_SETSP, 2), 32'h32);
    dl(IT_ACC, 13'h14);
    dl(IT_DEC, 13'h1E);
    rc(at(A_SETAC, 3), 32'h14);
    dl(IT_INIT, 13'h0);
    rc(at(A_SETDC, 3), 32'h5);
    rc(at(A_SETSP, 0), 32'h64);
    $display("test data sets done");
    wr(at(A_SETSP, 0), 32'hFA0);
    wr(at(A_SETSP, 1), 32'h0);
    wr(at(A_SETSP, 2), 32'h3C);
    wr(A_LIMIT, 32'h0BB80064);
    rc(at(A_SETSP, 0), 32'hBB8);
    rc(at(A_SETSP, 1), 32'h0);
    rc(at(A_SETSP, 2), 32'h64);
    wr(at(A_SETSP, 3), 32'hBB9);
    rc(at(A_SETSP, 3), 32'h64);
    wr(at(A_SETSP, 3), 32'hBB8);
    wr(at(A_SETSP, 3), 32'h63);
    rc(at(A_SETSP, 3), 32'hBB8);
    wr(A_LIMIT, 32'h0FA00032);
    $display("test limits done");
    wr(A_ICLR, 32'h1F);
    wr(A_IEN, 32'h8);
    wr(A_CTRL, 32'h4);
    dl(IT_SPEED, 13'h1F4);
    c = 0;
    chk(lock_notice_display, 1);
    chk(irq, 1);
    rc(at(A_SETSP, 3), 32'hBB8);
    wr(A_IEN, 32'h0);
    chk(irq, 0);
    wr(A_IEN, 32'h8);
    wr(A_ICLR, 32'h8);
    chk(irq, 0);
    rc(A_ISTAT, 32'h0);
    while (lock_notice_display === 1'b1)
    begin
      @(posedge mclk);
      if (++c > 60000) hang();
    end
    chk(c > 49800 && c < 50100, 1);
    wr(A_CTRL, 32'h0);
    $display("test lock done");
    set_no <= 2'h0;
    pass2();
    wr(A_CTRL, 32'h8);
    ramp(13'hBB8, 100);
    wr(A_CTRL, 32'h0);
    ramp(13'h0, 200);
    wr(at(A_SETSP, 0), 32'h5DC);
    wr(at(A_SETAC, 0), 32'h1);
    wr(at(A_SETDC, 0), 32'h2);
    wr(A_CTRL, 32'h9);
    ramp(13'h5DC, 100);
    wr(A_CTRL, 32'h1);
    ramp(13'h0, 200);
    $display("test ramps done");
    drift <= 8'sd100;
    pass2();
    chk({24'h0, hold_torque}, 32'h0);
    wr(A_CTRL, 32'h2);
    chk({24'h0, hold_torque}, 32'h32);
    drift <= -8'sd100;
    pass2();
    chk({24'h0, hold_torque}, 32'hCE);
    wr(A_CTRL, 32'hA);
    alarm_code_in <= 8'h21;
    alarm_in <= 1'b1;
    pass2();
    chk({drive_en, speed_cmd}, 14'h0);
    chk({24'h0, hold_torque}, 32'h0);
    chk(alarm_code, 32'h21);
    alarm_in <= 1'b0;
    @(posedge mclk);
    wr(A_CMD, 32'h200);
    pass2();
    chk(drive_en, 1);
    alarm_latch <= 1'b1;
    alarm_in <= 1'b1;
    pass2();
    alarm_in <= 1'b0;
    @(posedge mclk);
    wr(A_CMD, 32'h200);
    chk(drive_en, 0);
    reset <= 1'b1;
    alarm_latch <= 1'b0;
    pass2();
    reset <= 1'b0;
    @(posedge mclk);
    chk(drive_en, 1);
    $display("test alarms done");
    wr(A_CTRL, 32'hA);
    repeat (500) @(posedge mclk);
    ext_stop <= 1'b1;
    pass2();
    chk({brake, speed_cmd, hold_torque}, 22'h200000);
    chk(alarm_code, EXT_STOP_CD);
    ext_stop <= 1'b0;
    @(posedge mclk);
    wr(A_CTRL, 32'h0);
    @(posedge mclk);
    chk(brake, 0);
    warn_in <= 1'b1;
    pass2();
    chk(warning, 1);
    bus(1'b0, A_ISTAT, 32'h0);
    chk(rd[I_WARN], 1);
    $display("test stops done");
    end_of_test();
  end
endmodule // test_spd_ctrl
